// [amta_pkg.sv]
package amta_pkg;

    // ==========================================================
    // register map
    localparam logic [11:0] ADDR_ALARM_OUT = 12'h02c0;
    localparam logic [11:0] ADDR_ALARM_STATUS = 12'h02c1;
    localparam logic [11:0] ADDR_ALARM_MASKS = 12'h02c2;
    localparam logic [11:0] ADDR_LANE_ALARM = 12'h02c4;
    localparam logic [11:0] ADDR_TRIM_A_DUAL = 12'h0310;
    localparam logic [11:0] ADDR_TRIM_B_DUAL = 12'h0313;
    localparam logic [11:0] ADDR_TRIM_A_SINGLE = 12'h0314;
    localparam logic [11:0] ADDR_TRIM_B_SINGLE = 12'h0315;
    localparam logic [11:0] ADDR_OP_MODE = 12'h0300;

    // ==========================================================
    // field positions
    localparam int BIT_LANE_FIFO = 5;
    localparam int BIT_LOCK_LOSS = 4;
    localparam int BIT_SERIAL_LINK = 3;
    localparam int BIT_REALIGN = 2;
    localparam int BIT_OSC_PHASE = 1;
    localparam int BIT_DIV_MISMATCH = 0;
    localparam int BIT_MODE_SINGLE = 0;
    localparam int BIT_MODE_FG_CAL = 1;
    localparam int BIT_MODE_INB = 2;

    // ==========================================================
    // reset values
    localparam logic [5:0] RST_ALARM_MASKS = 6'h3f;
    localparam logic [5:0] RST_ALARM_STATUS = 6'h3f;
    localparam logic [15:0] RST_LANE_ALARM = 16'hffff;
    localparam logic [2:0] RST_OP_MODE = 3'h0;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [11:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } amta_req_t;

    typedef struct packed {
        logic [7:0] a_dual;
        logic [7:0] b_dual;
        logic [7:0] a_single;
        logic [7:0] b_single;
    } amta_trim_t;

endpackage

// [amta_regs.sv]
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// How it works
// - mask bit 5 blocks lane fifo flag
// - mask bit 4 blocks lock loss flag
// - mask bit 3 blocks serial link flag
// - mask bit 2 blocks realign flag
// - mask bit 1 blocks oscillator phase flag
// - mask bit 0 blocks divider mismatch flag
// - fault on an active lane sets its lane alarm bit
// - writing one clears lane bit, zero keeps
// - persisting fault sets lane bit again
// - clearing lane fifo flag clears all lanes
// - lane alarm bits all set after reset
// - trim registers drive core sampling delay
// - trims load factory values, software rewritable
// - 0x310 trims core a, dual mode
// - 0x313 trims core b, dual mode
// - 0x314 trims core a, single mode with cal on, input a
// - 0x315 trims core b, single mode with cal on, input a
// - any unmasked status flag raises alarm
// - any fault on an active lane sets lane fifo flag
module amta_regs #(
    parameter int LANES = 16,
    parameter logic [7:0] FUSE_A_DUAL = 8'h00,
    parameter logic [7:0] FUSE_B_DUAL = 8'h00,
    parameter logic [7:0] FUSE_A_SINGLE = 8'h00,
    parameter logic [7:0] FUSE_B_SINGLE = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [11:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    // alarm sources, level while condition holds
    input wire logic [LANES-1:0] lane_fault,
    input wire logic [LANES-1:0] lane_active,
    input wire logic [4:0] other_fault,
    // factory trim load, one-cycle pulse
    input wire logic fuse_load,
    // outputs
    output logic alarm_out,
    output logic [5:0] alarm_status,
    output logic [7:0] trim_core_a,
    output logic [7:0] trim_core_b,
    output amta_pkg::amta_trim_t trim_regs
);

    // ==========================================================
    // decode
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    amta_pkg::amta_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr_en, rd: rd_en};

    logic [5:0] mask_q;
    logic [5:0] status_q;
    logic [5:0] status_d;
    logic [LANES-1:0] lane_q;
    logic [LANES-1:0] lane_d;
    logic [2:0] mode_q;
    amta_pkg::amta_trim_t trim_q;
    logic [LANES-1:0] lane_hit;
    logic [5:0] src;
    logic status_clr_fifo;

    assign lane_hit = lane_fault & lane_active;
    assign src = {|lane_hit, other_fault};
    assign status_clr_fifo = req.wr && hit(req.addr, amta_pkg::ADDR_ALARM_STATUS)
        && req.wdata[amta_pkg::BIT_LANE_FIFO];

    // ==========================================================
    // mask register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= amta_pkg::RST_ALARM_MASKS;
        else if (req.wr && hit(req.addr, amta_pkg::ADDR_ALARM_MASKS))
            mask_q <= req.wdata[5:0];
    end

    // ==========================================================
    // status flags, set wins over write-one clear
    always_comb
    begin
        status_d = status_q;
        if (req.wr && hit(req.addr, amta_pkg::ADDR_ALARM_STATUS))
            status_d = status_q & ~req.wdata[5:0];
        status_d = status_d | src;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            status_q <= amta_pkg::RST_ALARM_STATUS;
        else
            status_q <= status_d;
    end

    // ==========================================================
    // per-lane alarm, one bit per lane
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++)
        begin : g_lane
            always_comb
            begin
                lane_d[gi] = lane_q[gi];
                if (status_clr_fifo)
                    lane_d[gi] = 1'b0;
                else if (req.wr && hit(req.addr, amta_pkg::ADDR_LANE_ALARM)
                    && req.wdata[gi])
                    lane_d[gi] = 1'b0;
                // a fault still present re-arms the bit at once
                if (lane_hit[gi])
                    lane_d[gi] = 1'b1;
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lane_q <= amta_pkg::RST_LANE_ALARM[LANES-1:0];
        else
            lane_q <= lane_d;
    end

    // ==========================================================
    // mode register: single channel, foreground cal, input b
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= amta_pkg::RST_OP_MODE;
        else if (req.wr && hit(req.addr, amta_pkg::ADDR_OP_MODE))
            mode_q <= req.wdata[2:0];
    end

    // ==========================================================
    // timing trims; fuse values load on the fuse strobe
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            trim_q <= '0;
        else if (fuse_load)
            trim_q <= '{a_dual: FUSE_A_DUAL, b_dual: FUSE_B_DUAL,
                a_single: FUSE_A_SINGLE, b_single: FUSE_B_SINGLE};
        else if (req.wr)
        begin
            if (hit(req.addr, amta_pkg::ADDR_TRIM_A_DUAL))
                trim_q.a_dual <= req.wdata[7:0];
            if (hit(req.addr, amta_pkg::ADDR_TRIM_B_DUAL))
                trim_q.b_dual <= req.wdata[7:0];
            if (hit(req.addr, amta_pkg::ADDR_TRIM_A_SINGLE))
                trim_q.a_single <= req.wdata[7:0];
            if (hit(req.addr, amta_pkg::ADDR_TRIM_B_SINGLE))
                trim_q.b_single <= req.wdata[7:0];
        end
    end

    // ==========================================================
    // trim selection; single mode sampling input b uses trims outside
    // this block, so the cores then hold the dual values
    logic single_ina;
    assign single_ina = mode_q[amta_pkg::BIT_MODE_SINGLE]
        && mode_q[amta_pkg::BIT_MODE_FG_CAL]
        && !mode_q[amta_pkg::BIT_MODE_INB];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trim_core_a <= '0;
            trim_core_b <= '0;
        end
        else if (single_ina)
        begin
            trim_core_a <= trim_q.a_single;
            trim_core_b <= trim_q.b_single;
        end
        else
        begin
            trim_core_a <= trim_q.a_dual;
            trim_core_b <= trim_q.b_dual;
        end
    end

    // ==========================================================
    // aggregated alarm, registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alarm_out <= 1'b0;
            alarm_status <= amta_pkg::RST_ALARM_STATUS;
            trim_regs <= '0;
        end
        else
        begin
            alarm_out <= |(status_d & ~mask_q);
            alarm_status <= status_d;
            trim_regs <= trim_q;
        end
    end

    // ==========================================================
    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= '0;
        else if (!req.rd)
            rdata <= '0;
        else
            case (req.addr)
                amta_pkg::ADDR_ALARM_OUT: rdata <= {15'h0000, alarm_out};
                amta_pkg::ADDR_ALARM_STATUS: rdata <= {10'h000, status_q};
                amta_pkg::ADDR_ALARM_MASKS: rdata <= {10'h000, mask_q};
                amta_pkg::ADDR_LANE_ALARM:
                    rdata <= 16'(lane_q);
                amta_pkg::ADDR_OP_MODE: rdata <= {13'h0000, mode_q};
                amta_pkg::ADDR_TRIM_A_DUAL: rdata <= {8'h00, trim_q.a_dual};
                amta_pkg::ADDR_TRIM_B_DUAL: rdata <= {8'h00, trim_q.b_dual};
                amta_pkg::ADDR_TRIM_A_SINGLE:
                    rdata <= {8'h00, trim_q.a_single};
                amta_pkg::ADDR_TRIM_B_SINGLE:
                    rdata <= {8'h00, trim_q.b_single};
                default: rdata <= '0;
            endcase
    end

    // ==========================================================
    // checks
    // outputs are registered, so each check looks one edge after its cause, except p_lane_set, which checks alarm_status one edge later still
    property p_mask_fifo;
        @(posedge clk) disable iff (!rst_n)
        (mask_q[amta_pkg::BIT_LANE_FIFO] && status_d[5:0] == 6'h20)
            |=> !alarm_out;
    endproperty
    a_mask_fifo: assert property (p_mask_fifo) else $error("masked fifo");

    property p_mask_lock;
        @(posedge clk) disable iff (!rst_n)
        (mask_q[amta_pkg::BIT_LOCK_LOSS] && status_d == 6'h10)
            |=> !alarm_out;
    endproperty
    a_mask_lock: assert property (p_mask_lock) else $error("masked lock");

    property p_mask_link;
        @(posedge clk) disable iff (!rst_n)
        (mask_q[amta_pkg::BIT_SERIAL_LINK] && status_d == 6'h08)
            |=> !alarm_out;
    endproperty
    a_mask_link: assert property (p_mask_link) else $error("masked link");

    property p_mask_algn;
        @(posedge clk) disable iff (!rst_n)
        (mask_q[amta_pkg::BIT_REALIGN] && status_d == 6'h04)
            |=> !alarm_out;
    endproperty
    a_mask_algn: assert property (p_mask_algn) else $error("masked algn");

    property p_mask_osc;
        @(posedge clk) disable iff (!rst_n)
        (mask_q[amta_pkg::BIT_OSC_PHASE] && status_d == 6'h02)
            |=> !alarm_out;
    endproperty
    a_mask_osc: assert property (p_mask_osc) else $error("masked osc");

    property p_mask_div;
        @(posedge clk) disable iff (!rst_n)
        (mask_q[amta_pkg::BIT_DIV_MISMATCH] && status_d == 6'h01)
            |=> !alarm_out;
    endproperty
    a_mask_div: assert property (p_mask_div) else $error("masked div");

    property p_mask_all;
        @(posedge clk) disable iff (!rst_n)
        (mask_q == 6'h3f) |=> !alarm_out;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("masked alarm");

    property p_unmasked;
        @(posedge clk) disable iff (!rst_n)
        ((status_d & ~mask_q) != 6'h00) |=> alarm_out;
    endproperty
    a_unmasked: assert property (p_unmasked)
        else $error("alarm missing");

    property p_lane_set;
        @(posedge clk) disable iff (!rst_n)
        lane_hit[0] |=> lane_q[0] ##1 alarm_status[5];
    endproperty
    a_lane_set: assert property (p_lane_set) else $error("lane not set");

    property p_lane_clr;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && hit(req.addr, amta_pkg::ADDR_LANE_ALARM) && req.wdata[0]
            && !lane_hit[0]) |=> !lane_q[0];
    endproperty
    a_lane_clr: assert property (p_lane_clr) else $error("lane clr");

    property p_lane_keep;
        @(posedge clk) disable iff (!rst_n)
        (lane_q[1] && !status_clr_fifo && !(req.wr && req.wdata[1]))
            |=> lane_q[1];
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("lane lost");

    property p_clr_all;
        @(posedge clk) disable iff (!rst_n)
        (status_clr_fifo && lane_hit == '0) |=> lane_q == '0;
    endproperty
    a_clr_all: assert property (p_clr_all) else $error("clear all");

    property p_trim_dual;
        @(posedge clk) disable iff (!rst_n)
        (!mode_q[amta_pkg::BIT_MODE_SINGLE])
            |=> trim_core_a == $past(trim_q.a_dual);
    endproperty
    a_trim_dual: assert property (p_trim_dual) else $error("trim a");

    property p_trim_rd;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && hit(req.addr, amta_pkg::ADDR_TRIM_B_DUAL))
            |=> rdata[7:0] == $past(trim_q.b_dual);
    endproperty
    a_trim_rd: assert property (p_trim_rd) else $error("trim read");

    property p_trim_bd;
        @(posedge clk) disable iff (!rst_n)
        !single_ina |=> trim_core_b == $past(trim_q.b_dual);
    endproperty
    a_trim_bd: assert property (p_trim_bd) else $error("trim b");

    property p_trim_as;
        @(posedge clk) disable iff (!rst_n)
        single_ina |=> trim_core_a == $past(trim_q.a_single);
    endproperty
    a_trim_as: assert property (p_trim_as) else $error("trim a single");

    property p_trim_bs;
        @(posedge clk) disable iff (!rst_n)
        single_ina |=> trim_core_b == $past(trim_q.b_single);
    endproperty
    a_trim_bs: assert property (p_trim_bs) else $error("trim b single");

    property p_fuse;
        @(posedge clk) disable iff (!rst_n)
        fuse_load |=> trim_q.a_dual == FUSE_A_DUAL
            && trim_q.b_single == FUSE_B_SINGLE;
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse load");

    property p_lane_rearm;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && hit(req.addr, amta_pkg::ADDR_LANE_ALARM) && req.wdata[0]
            && lane_hit[0]) |=> lane_q[0];
    endproperty
    a_lane_rearm: assert property (p_lane_rearm) else $error("rearm");

    property p_lane_idle;
        @(posedge clk) disable iff (!rst_n)
        (!lane_q[2] && !lane_hit[2]) |=> !lane_q[2];
    endproperty
    a_lane_idle: assert property (p_lane_idle) else $error("lane idle");

    c_alarm: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(alarm_out));
    c_lane_rearm: cover property (@(posedge clk) disable iff (!rst_n)
        (req.wr && hit(req.addr, amta_pkg::ADDR_LANE_ALARM)
            && lane_hit != '0));
    c_single: cover property (@(posedge clk) disable iff (!rst_n)
        single_ina);

endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    // ==========================================================
    // signals
    logic clk, rst_n, wr_en, rd_en, fuse_load, alarm_out;
    logic [11:0] addr;
    logic [15:0] wdata, rdata, lane_fault, lane_active, f, w;
    logic [4:0] other_fault;
    logic [5:0] alarm_status;
    logic [7:0] trim_core_a, trim_core_b;
    amta_pkg::amta_trim_t trim_regs;
    int failures, checks;
    logic [31:0] seed;
    logic [7:0] tv [4];
    logic [11:0] ta [4];
    // fuse values are arbitrary, only distinct
    localparam logic [7:0] FV0 = 8'h5a, FV1 = 8'ha5, FV2 = 8'h3c, FV3 = 8'hc3;

    amta_regs #(.FUSE_A_DUAL(FV0), .FUSE_B_DUAL(FV1),
        .FUSE_A_SINGLE(FV2), .FUSE_B_SINGLE(FV3)) uut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .lane_fault(lane_fault), .lane_active(lane_active),
        .other_fault(other_fault), .fuse_load(fuse_load),
        .alarm_out(alarm_out), .alarm_status(alarm_status),
        .trim_core_a(trim_core_a), .trim_core_b(trim_core_b),
        .trim_regs(trim_regs));

    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // single channel, cal on, input a picks the single-mode trims
    function automatic logic sel(logic [2:0] m);
        return m[amta_pkg::BIT_MODE_SINGLE] & m[amta_pkg::BIT_MODE_FG_CAL]
            & ~m[amta_pkg::BIT_MODE_INB];
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic wr(logic [11:0] a, logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(logic [11:0] a, logic [15:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #40000;
        failures++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        lane_fault = '0;
        lane_active = '1;
        other_fault = '0;
        fuse_load = 1'b0;
        failures = 0;
        checks = 0;
        seed = 32'h0000_ad47;
        ta = '{amta_pkg::ADDR_TRIM_A_DUAL, amta_pkg::ADDR_TRIM_B_DUAL,
            amta_pkg::ADDR_TRIM_A_SINGLE, amta_pkg::ADDR_TRIM_B_SINGLE};
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(amta_pkg::ADDR_LANE_ALARM, 16'hffff);
        rd(amta_pkg::ADDR_ALARM_MASKS, 16'h003f);
        rd(amta_pkg::ADDR_ALARM_STATUS, 16'h003f);
        rd(amta_pkg::ADDR_ALARM_OUT, 16'h0000);
        for (int i = 0; i < 4; i++) rd(ta[i], 16'h0000);
        rd(12'h0123, 16'h0000);
        @(posedge clk);
        #1;
        chk(rdata, 16'h0000);
        // clear the reset-time flags with no fault present
        wr(amta_pkg::ADDR_ALARM_STATUS, 16'h003f);
        wr(amta_pkg::ADDR_LANE_ALARM, 16'hffff);
        rd(amta_pkg::ADDR_LANE_ALARM, 16'h0000);
        // each source: own mask bit alone blocks it, clearing it lets it out
        for (int i = 0; i < 6; i++)
        begin
            wr(amta_pkg::ADDR_ALARM_MASKS, 16'h0001 << i);
            @(posedge clk);
            if (i == 5) lane_fault <= 16'h0001 << (rnd() % 16);
            else other_fault <= 5'h01 << i;
            repeat (3) @(posedge clk);
            #1;
            chk(alarm_out, 1'b0);
            chk(alarm_status, 6'h01 << i);
            wr(amta_pkg::ADDR_ALARM_MASKS, 16'h0000);
            repeat (2) @(posedge clk);
            #1;
            chk(alarm_out, 1'b1);
            rd(amta_pkg::ADDR_ALARM_OUT, 16'h0001);
            @(posedge clk);
            lane_fault <= '0;
            other_fault <= '0;
            wr(amta_pkg::ADDR_ALARM_STATUS, 16'h0001 << i);
            repeat (2) @(posedge clk);
            #1;
            chk(alarm_out, 1'b0);
            rd(amta_pkg::ADDR_LANE_ALARM, 16'h0000);
        end
        // random lane faults, inactive lanes ignored, partial clears
        for (int k = 0; k < 4; k++)
        begin
            f = rnd() | 16'h0001;
            w = rnd();
            @(posedge clk);
            lane_active <= (rnd() | 16'h0001);
            lane_fault <= f;
            repeat (2) @(posedge clk);
            lane_fault <= '0;
            f = f & lane_active;
            repeat (2) @(posedge clk);
            rd(amta_pkg::ADDR_LANE_ALARM, f);
            rd(amta_pkg::ADDR_ALARM_STATUS, 16'h0020);
            wr(amta_pkg::ADDR_LANE_ALARM, w);
            rd(amta_pkg::ADDR_LANE_ALARM, f & ~w);
            wr(amta_pkg::ADDR_ALARM_STATUS, 16'h0020);
            rd(amta_pkg::ADDR_LANE_ALARM, 16'h0000);
        end
        @(posedge clk);
        lane_active <= '1;
        lane_fault <= 16'h8001;
        wr(amta_pkg::ADDR_LANE_ALARM, 16'hffff);
        rd(amta_pkg::ADDR_LANE_ALARM, 16'h8001);
        @(posedge clk);
        lane_fault <= '0;
        wr(amta_pkg::ADDR_ALARM_STATUS, 16'h0020);
        rd(amta_pkg::ADDR_LANE_ALARM, 16'h0000);
        // factory trims, then software overrides and mode selection
        @(posedge clk);
        fuse_load <= 1'b1;
        @(posedge clk);
        fuse_load <= 1'b0;
        tv = '{FV0, FV1, FV2, FV3};
        for (int i = 0; i < 4; i++) rd(ta[i], {8'h00, tv[i]});
        for (int i = 0; i < 4; i++)
        begin
            tv[i] = rnd();
            wr(ta[i], {8'hff, tv[i]});
        end
        for (int i = 0; i < 4; i++) rd(ta[i], {8'h00, tv[i]});
        for (int m = 0; m < 8; m++)
        begin
            wr(amta_pkg::ADDR_OP_MODE, m);
            repeat (3) @(posedge clk);
            #1;
            chk(trim_core_a, sel(m) ? tv[2] : tv[0]);
            chk(trim_core_b, sel(m) ? tv[3] : tv[1]);
            chk(trim_regs, {tv[0], tv[1], tv[2], tv[3]});
        end
        tally_and_finish();
    end
endmodule
